// *** src/sadc_top.sv ***
// converter control block: Avalon-MM registers, pin roles, conversion sequencing
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_top #(
  parameter int CHANNELS = 8,
  parameter int WIDTH    = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire logic [11:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [CHANNELS-1:0]  pin_level,
  output logic [CHANNELS-1:0]       pin_analog_mask,
  output logic                      vref_from_pin,
  output logic                      vref_valid,
  output logic [2:0]                mux_channel,
  output logic                      converter_enable,
  output logic                      hold_connect,
  output logic [WIDTH-1:0]          dac_code,
  input  wire logic                 cmp_above,
  output logic                      conversion_complete_flag
);
  import sadc_pkg::*;

  // register state
  logic [1:0]       clk_sel_q;
  logic [2:0]       chan_q;
  logic             go_q;
  logic             power_q;
  logic [2:0]       pin_role_q;
  logic [WIDTH-1:0] result_q;
  logic             flag_q;
  logic [31:0]      rdata_q;
  logic             ack_q;
  sadc_state_t      state_q;
  sadc_state_t      state_d;
  logic [2:0]       hold_cnt_q;

  // bus decode
  logic [9:0]       idx;
  logic             req;
  logic             wr_en;
  logic             hit_ctrl;
  logic             hit_cfg;
  logic             hit_res;
  logic             hit_flag;
  logic             hit_port;
  logic [7:0]       wbyte;
  logic [31:0]      rmux;

  // sequencing
  logic             start_conv;
  logic             abort_conv;
  logic             half_tick;
  logic             sar_done;
  logic [WIDTH-1:0] sar_result;
  logic [CHANNELS-1:0] port_read;
  logic [CHANNELS-1:0] analog_mask;

  assign idx      = avs_address[11:2];
  assign req      = avs_read || avs_write;
  assign wbyte    = avs_writedata[7:0];
  assign hit_ctrl = (idx == `SADC_IDX_CTRL_MAIN);
  assign hit_cfg  = (idx == `SADC_IDX_PORT_CFG);
  assign hit_res  = (idx == `SADC_IDX_RESULT);
  assign hit_flag = (idx == `SADC_IDX_FLAGS);
  assign hit_port = (idx == `SADC_IDX_PORT_DATA);

  // one wait cycle per access; the read sample is taken on the wait edge, one edge before the write lands
  assign avs_waitrequest = req && !ack_q;
  assign wr_en           = avs_write && ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // pin role decode from the configuration code
  always_comb begin
    unique case (pin_role_q)
      3'h0: analog_mask = CHANNELS'(`SADC_MASK_CFG0);
      3'h1: analog_mask = CHANNELS'(`SADC_MASK_CFG1);
      3'h2: analog_mask = CHANNELS'(`SADC_MASK_CFG2);
      3'h3: analog_mask = CHANNELS'(`SADC_MASK_CFG3);
      3'h4: analog_mask = CHANNELS'(`SADC_MASK_CFG4);
      3'h5: analog_mask = CHANNELS'(`SADC_MASK_CFG5);
      3'h6: analog_mask = CHANNELS'(`SADC_MASK_DIGITAL);
      3'h7: analog_mask = CHANNELS'(`SADC_MASK_DIGITAL);
    endcase
  end

  // odd codes below 6 take the reference from the pin, codes 11x have none
  assign vref_from_pin   = pin_role_q[0] && (pin_role_q[2:1] != 2'b11);
  assign vref_valid      = (pin_role_q[2:1] != 2'b11);
  assign pin_analog_mask = analog_mask;

  // analog pins read back low on the port data register
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_port
      assign port_read[g] = pin_level[g] && !analog_mask[g];
    end
  endgenerate

  // the mux follows the channel code alone, so digital pins and driven outputs are converted too
  assign mux_channel      = chan_q;
  assign converter_enable = power_q;
  // capacitor tracks the input only while idle; disconnected during conversion and holdoff
  assign hold_connect     = power_q && (state_q == SADC_ST_IDLE);

  // read data mux
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_ctrl) begin
      rmux[`SADC_CTRL_CLK_HI:`SADC_CTRL_CLK_LO]   = clk_sel_q;
      rmux[`SADC_CTRL_CHAN_HI:`SADC_CTRL_CHAN_LO] = chan_q;
      rmux[`SADC_CTRL_GO]                         = go_q;
      rmux[`SADC_CTRL_PWR]                        = power_q;
    end else if (hit_cfg) begin
      rmux[`SADC_CFG_HI:`SADC_CFG_LO] = pin_role_q;
    end else if (hit_res) begin
      rmux[WIDTH-1:0] = result_q;
    end else if (hit_flag) begin
      rmux[`SADC_FLAG_DONE] = flag_q;
    end else if (hit_port) begin
      rmux[CHANNELS-1:0] = port_read;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rmux;
    end
  end

  // configuration register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_role_q <= `SADC_RST_CFG;
    end else if (wr_en && hit_cfg) begin
      pin_role_q <= wbyte[`SADC_CFG_HI:`SADC_CFG_LO];
    end
  end

  // control fields other than go
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clk_sel_q <= 2'(`SADC_RST_BYTE >> `SADC_CTRL_CLK_LO);
      chan_q    <= 3'h0;
      power_q   <= 1'b0;
    end else if (wr_en && hit_ctrl) begin
      clk_sel_q <= wbyte[`SADC_CTRL_CLK_HI:`SADC_CTRL_CLK_LO];
      chan_q    <= wbyte[`SADC_CTRL_CHAN_HI:`SADC_CTRL_CHAN_LO];
      power_q   <= wbyte[`SADC_CTRL_PWR];
    end
  end

  // a start needs power already on and the sequencer idle; go=0 during conversion aborts
  assign start_conv = wr_en && hit_ctrl && wbyte[`SADC_CTRL_GO] && power_q
                      && (state_q == SADC_ST_IDLE);
  assign abort_conv = (state_q == SADC_ST_CONV) && !sar_done
                      && ((wr_en && hit_ctrl && !wbyte[`SADC_CTRL_GO])
                          || (wr_en && hit_ctrl && !wbyte[`SADC_CTRL_PWR]));

  sadc_tad_gen u_tad (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .clk_sel   (sadc_clk_sel_t'(clk_sel_q)),
    .align     (start_conv),
    .half_tick (half_tick)
  );

  sadc_sar #(
    .WIDTH (WIDTH)
  ) u_sar (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .start     (start_conv),
    .abort     (abort_conv),
    .half_tick (half_tick),
    .cmp_above (cmp_above),
    .busy      (),
    .done      (sar_done),
    .dac_code  (dac_code),
    .result    (sar_result)
  );

  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SADC_ST_IDLE: begin
        if (start_conv) begin
          state_d = SADC_ST_CONV;
        end
      end
      SADC_ST_CONV: begin
        if (sar_done || abort_conv) begin
          state_d = SADC_ST_HOLDOFF;
        end
      end
      SADC_ST_HOLDOFF: begin
        if (half_tick && hold_cnt_q == 3'(`SADC_HOLDOFF_HALF_TADS - 1)) begin
          state_d = SADC_ST_IDLE;
        end
      end
      default: state_d = SADC_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= SADC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // two bit periods counted in half ticks after every conversion or abort
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != SADC_ST_HOLDOFF) begin
      hold_cnt_q <= 3'h0;
    end else if (half_tick) begin
      hold_cnt_q <= hold_cnt_q + 3'h1;
    end
  end

  // go bit: set by software start, cleared by hardware at completion or abort
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      go_q <= 1'b0;
    end else if (start_conv) begin
      go_q <= 1'b1;
    end else if (sar_done || abort_conv) begin
      go_q <= 1'b0;
    end
  end

  // result: loaded at completion, also writable; completion wins a same-cycle write
  // the RC bit period is generated on ref_clk, so the load is already in the register domain
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      result_q <= '0;
    end else if (sar_done) begin
      result_q <= sar_result;
    end else if (wr_en && hit_res) begin
      result_q <= wbyte[WIDTH-1:0];
    end
  end

  // completion flag: sticky, software clears by writing zero, a completion in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (sar_done) begin
      flag_q <= 1'b1;
    end else if (wr_en && hit_flag) begin
      flag_q <= wbyte[`SADC_FLAG_DONE];
    end
  end

  assign conversion_complete_flag = flag_q;
endmodule

// *** src/sadc_map.svh ***
// register map, field positions, reset values and timing constants of the converter control block
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

// register indices; byte address is four times the index
`define SADC_IDX_PORT_DATA    10'h005
`define SADC_IDX_FLAGS        10'h00c
`define SADC_IDX_RESULT       10'h01e
`define SADC_IDX_CTRL_MAIN    10'h01f
`define SADC_IDX_PORT_CFG     10'h09f

// converter_control_main fields
`define SADC_CTRL_CLK_HI      7
`define SADC_CTRL_CLK_LO      6
`define SADC_CTRL_CHAN_HI     5
`define SADC_CTRL_CHAN_LO     3
`define SADC_CTRL_GO          2
`define SADC_CTRL_PWR         0
// flags register field
`define SADC_FLAG_DONE        6
// analog_port_config field
`define SADC_CFG_HI           2
`define SADC_CFG_LO           0

`define SADC_RST_BYTE         8'h00
`define SADC_RST_CFG          3'h0

// analog pin masks per configuration code, bit n is channel n
`define SADC_MASK_CFG0        8'hff
`define SADC_MASK_CFG1        8'hf7
`define SADC_MASK_CFG2        8'h1f
`define SADC_MASK_CFG3        8'h17
`define SADC_MASK_CFG4        8'h0b
`define SADC_MASK_CFG5        8'h03
`define SADC_MASK_DIGITAL     8'h00

// timing
`define SADC_CLK_PERIOD_NS    100
`define SADC_RC_TAD_NS        4000
`define SADC_HALF_TAD_2TOSC   1
`define SADC_HALF_TAD_8TOSC   4
`define SADC_HALF_TAD_32TOSC  16
`define SADC_HALF_TAD_RC      ((`SADC_RC_TAD_NS / 2) / `SADC_CLK_PERIOD_NS)
`define SADC_CONV_HALF_TADS   19
`define SADC_HOLDOFF_HALF_TADS 4

`endif

// *** src/sadc_pkg.sv ***
// types shared by the converter control block
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_CLK_2TOSC  = 2'b00,
    SADC_CLK_8TOSC  = 2'b01,
    SADC_CLK_32TOSC = 2'b10,
    SADC_CLK_RC     = 2'b11
  } sadc_clk_sel_t;

  typedef enum logic [1:0] {
    SADC_ST_IDLE    = 2'b00,
    SADC_ST_CONV    = 2'b01,
    SADC_ST_HOLDOFF = 2'b10
  } sadc_state_t;
endpackage

// *** src/sadc_tad_gen.sv ***
// half bit-period tick generator for the conversion clock
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_tad_gen (
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  input  wire sadc_pkg::sadc_clk_sel_t clk_sel,
  input  wire logic                   align,
  output logic                        half_tick
);
  import sadc_pkg::*;

  logic [5:0] cnt_q;
  logic [5:0] limit;

  // RC period is derived from ref_clk, so no separate clock domain exists
  always_comb begin
    unique case (clk_sel)
      SADC_CLK_2TOSC:  limit = 6'(`SADC_HALF_TAD_2TOSC);
      SADC_CLK_8TOSC:  limit = 6'(`SADC_HALF_TAD_8TOSC);
      SADC_CLK_32TOSC: limit = 6'(`SADC_HALF_TAD_32TOSC);
      SADC_CLK_RC:     limit = 6'(`SADC_HALF_TAD_RC);
    endcase
  end

  assign half_tick = (cnt_q == limit - 6'h01) && !align;

  always_ff @(posedge ref_clk) begin
    if (srst || align || half_tick) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule

// *** src/sadc_sar.sv ***
// successive approximation register: 19 half bit-periods per conversion
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_sar #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             half_tick,
  input  wire logic             cmp_above,
  output logic                  busy,
  output logic                  done,
  output logic [WIDTH-1:0]      dac_code,
  output logic [WIDTH-1:0]      result
);
  logic [4:0]       cnt_q;
  logic [WIDTH-1:0] code_q;
  logic [WIDTH-1:0] trial_q;
  logic             busy_q;

  assign busy     = busy_q;
  assign dac_code = code_q | trial_q;
  assign result   = code_q;
  // decisions on odd half ticks 3..17, finish on the 19th
  assign done     = busy_q && half_tick && (cnt_q == 5'(`SADC_CONV_HALF_TADS - 1));

  always_ff @(posedge ref_clk) begin
    if (srst || abort) begin
      busy_q  <= 1'b0;
      cnt_q   <= 5'h00;
      code_q  <= '0;
      trial_q <= '0;
    end else if (start) begin
      busy_q  <= 1'b1;
      cnt_q   <= 5'h00;
      code_q  <= '0;
      trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (busy_q && half_tick) begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q[0] && cnt_q >= 5'h03 && trial_q != '0) begin
        if (!cmp_above) begin
          code_q <= code_q | trial_q;
        end
        trial_q <= trial_q >> 1;
      end
      if (done) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule

// *** verification/sadc_top_assertions.sv ***
// assertion checker for the converter control block, bound to its top module
`timescale 1ns/1ps
module sadc_top_chk #(
  parameter int CHANNELS = 8,
  parameter int WIDTH    = 8
) (
  input wire logic                ref_clk,
  input wire logic                srst,
  input wire logic [11:0]         avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic [CHANNELS-1:0] pin_level,
  input wire logic [CHANNELS-1:0] pin_analog_mask,
  input wire logic                vref_from_pin,
  input wire logic                vref_valid,
  input wire logic [2:0]          mux_channel,
  input wire logic                converter_enable,
  input wire logic                hold_connect,
  input wire logic [WIDTH-1:0]    dac_code,
  input wire logic                cmp_above,
  input wire logic                conversion_complete_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [9:0]  idx;
  logic        rd_ok;
  logic        wr_ok;
  logic [15:0] cnt_q;
  assign idx = avs_address[11:2];
  assign rd_ok = avs_read && !avs_waitrequest;
  assign wr_ok = avs_write && !avs_waitrequest;
  // cycles with the capacitor disconnected; saturates so a long power-off cannot wrap
  always_ff @(posedge ref_clk) begin
    if (srst || hold_connect) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
  end
  property p_ref_gone; (pin_analog_mask == '0) == !vref_valid; endproperty
  a_ref_gone: assert property (p_ref_gone) else $error("reference valid does not track digital code");
  property p_ref_pin; vref_from_pin |-> vref_valid && !pin_analog_mask[3]; endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference pin still marked analog");
  property p_cfg_upper; rd_ok && idx == 10'h09f |-> avs_readdata[31:3] == '0; endproperty
  a_cfg_upper: assert property (p_cfg_upper) else $error("unimplemented config bits read nonzero");
  property p_port_zero; rd_ok && idx == 10'h005 |-> (avs_readdata[CHANNELS-1:0] & pin_analog_mask) == '0; endproperty
  a_port_zero: assert property (p_port_zero) else $error("analog pin reads high in port data");
  property p_conv_len;
    $rose(conversion_complete_flag) && !$past(wr_ok && idx == 10'h00c) |-> cnt_q inside {19, 76, 304, 380};
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length is not 9.5 bit periods");
  property p_holdoff;
    $rose(conversion_complete_flag) && !$past(wr_ok && idx == 10'h00c) |-> !hold_connect [*4];
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("capacitor reconnected too soon");
  property p_hold_power; hold_connect |-> converter_enable; endproperty
  a_hold_power: assert property (p_hold_power) else $error("sampling while converter off");
  property p_start_hold;
    wr_ok && idx == 10'h01f && avs_writedata[2] && converter_enable && hold_connect |=> !hold_connect;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("capacitor still connected after a start");
  property p_mux_write; $changed(mux_channel) |-> $past(wr_ok && idx == 10'h01f); endproperty
  a_mux_write: assert property (p_mux_write) else $error("channel changed without a write");
  c_done: cover property ($rose(conversion_complete_flag));
  c_cfg_read: cover property (rd_ok && idx == 10'h09f);
  c_no_ref: cover property (!vref_valid);
endmodule

bind sadc_top sadc_top_chk #(.CHANNELS(CHANNELS), .WIDTH(WIDTH)) sadc_top_chk_inst (.ref_clk(ref_clk),
  .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pin_level(pin_level), .pin_analog_mask(pin_analog_mask), .vref_from_pin(vref_from_pin),
  .vref_valid(vref_valid), .mux_channel(mux_channel), .converter_enable(converter_enable),
  .hold_connect(hold_connect), .dac_code(dac_code), .cmp_above(cmp_above),
  .conversion_complete_flag(conversion_complete_flag));

// *** verification/sadc_pin_model.sv ***
// analog pins and comparator on the far side of the converter
`timescale 1ns/1ps
module sadc_pin_model (
  input wire logic        ref_clk,
  input wire logic [63:0] chan_values,
  input wire logic [2:0]  mux_channel,
  input wire logic        converter_enable,
  input wire logic [7:0]  dac_code,
  output logic [7:0]      pin_level,
  output logic            cmp_above
);
  logic       idle_q = 1'b0;
  logic [7:0] sel_v;
  // comparator off means no meaningful output: toggle so nothing settles by luck
  always_ff @(posedge ref_clk) idle_q <= ~idle_q;
  assign sel_v = chan_values[mux_channel*8 +: 8];
  // all pins left as inputs; each shows the digital reading of its level
  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign pin_level[i] = chan_values[i*8+7];
  end
  // ideal comparator: a bit period under the minimum, or the rc clock on a fast device clock,
  // would only cost accuracy in silicon, so every clock choice can be exercised here
  assign cmp_above = converter_enable ? (dac_code > sel_v) : idle_q;
endmodule

// *** verification/sadc_top_bench.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sadc_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module sadc_top_bench;
  localparam logic [63:0] CHV = 64'hc3a75a01ff803c96;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pin_level, pin_analog_mask, dac_code;
  logic [2:0]  mux_channel;
  logic        vref_from_pin, vref_valid, converter_enable, hold_connect, cmp_above, flag;
  logic [31:0] rd;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [7:0]  masks [8] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00, 8'h00};
  sadc_top sadc_top_inst (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_level(pin_level), .pin_analog_mask(pin_analog_mask),
    .vref_from_pin(vref_from_pin), .vref_valid(vref_valid), .mux_channel(mux_channel),
    .converter_enable(converter_enable), .hold_connect(hold_connect), .dac_code(dac_code),
    .cmp_above(cmp_above), .conversion_complete_flag(flag));
  sadc_pin_model sadc_pin_model_inst (.ref_clk(ref_clk), .chan_values(CHV), .mux_channel(mux_channel),
    .converter_enable(converter_enable), .dac_code(dac_code), .pin_level(pin_level), .cmp_above(cmp_above));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // one access: raised after an edge, held until waitrequest is seen low at a rising edge,
  // where read data are taken and the request is dropped; the leading edge keeps accesses apart
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic conv(input logic [1:0] sel, input logic [2:0] ch);
    int n;
    int h;
    h = (sel == 2'd0) ? 1 : (sel == 2'd1) ? 4 : (sel == 2'd2) ? 16 : 20;
    bus(1'b1, `SADC_IDX_CTRL_MAIN, {sel, ch, 3'b001}, rd);
    repeat (120) @(posedge ref_clk);
    bus(1'b1, `SADC_IDX_CTRL_MAIN, {sel, ch, 3'b101}, rd);
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end while (flag !== 1'b1 && n < 1000);
    `CHK(n, 19 * h)
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end while (hold_connect !== 1'b1 && n < 1000);
    `CHK(n, 4 * h)
    bus(1'b0, `SADC_IDX_RESULT, 8'h00, rd);
    `CHK(rd, {24'h0, CHV[ch*8 +: 8]})
    bus(1'b0, `SADC_IDX_CTRL_MAIN, 8'h00, rd);
    `CHK(rd, {24'h0, sel, ch, 3'b001})
    bus(1'b0, `SADC_IDX_FLAGS, 8'h00, rd);
    `CHK(rd[6], 1'b1)
    bus(1'b1, `SADC_IDX_FLAGS, 8'h00, rd);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    bus(1'b0, `SADC_IDX_PORT_CFG, 8'h00, rd);
    `CHK(rd, 32'h0)
    bus(1'b0, 10'h100, 8'h00, rd);
    `CHK(rd, 32'h0)
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, `SADC_IDX_PORT_CFG, 8'hf8 | 8'(c), rd);
      bus(1'b0, `SADC_IDX_PORT_CFG, 8'h00, rd);
      `CHK(rd, {29'h0, 3'(c)})
      `CHK(pin_analog_mask, masks[c])
      `CHK(vref_valid, 1'(c < 6))
      `CHK(vref_from_pin, 1'(c == 1 || c == 3 || c == 5))
      bus(1'b0, `SADC_IDX_PORT_DATA, 8'h00, rd);
      `CHK(rd[7:0], pin_level & ~masks[c])
    end
    $display("test port roles done");
    bus(1'b1, `SADC_IDX_CTRL_MAIN, 8'h04, rd);
    repeat (40) @(posedge ref_clk);
    bus(1'b0, `SADC_IDX_CTRL_MAIN, 8'h00, rd);
    `CHK(rd, 32'h0)
    `CHK(flag, 1'b0)
    $display("test power off done");
    for (int s = 0; s < 4; s++) begin
      conv(2'(s), {2'(s), 1'b1});
    end
    $display("test conversions done");
    bus(1'b1, `SADC_IDX_CTRL_MAIN, 8'h81, rd);
    repeat (120) @(posedge ref_clk);
    bus(1'b1, `SADC_IDX_CTRL_MAIN, 8'h85, rd);
    repeat (40) @(posedge ref_clk);
    // go cleared mid-conversion: no result load, no flag, then the two bit period holdoff
    bus(1'b1, `SADC_IDX_CTRL_MAIN, 8'h81, rd);
    repeat (100) @(posedge ref_clk);
    `CHK(hold_connect, 1'b1)
    bus(1'b0, `SADC_IDX_FLAGS, 8'h00, rd);
    `CHK(rd[6], 1'b0)
    bus(1'b0, `SADC_IDX_RESULT, 8'h00, rd);
    `CHK(rd, {24'h0, CHV[63:56]})
    bus(1'b0, `SADC_IDX_CTRL_MAIN, 8'h00, rd);
    `CHK(rd, 32'h81)
    $display("test abort done");
    end_of_test();
  end
endmodule
